// file: logic/afs_top.sv
// serial output formatter of a dual 12-bit converter: coding, test
// patterns, latency and driver settings behind a classic wishbone slave
// assumes sample clock and core codes arrive asynchronously to clk_in
//
// Operation
// - two's complement after reset, offset binary when format bit set
// - positive overdrive clamps to 0xfff offset binary, 0x7ff two's complement
// - negative overdrive clamps to 0x000 offset binary, 0x800 two's complement
// - driver current resets to 3.5 ma, may select 2.5, 3.0 or 4.5
// - current double bit doubles the selected driver current
// - any subset of five termination legs may be enabled together
// - clock and data buffers have separate termination fields
// - deskew mode sends alternating ones and zeros on every wire
// - frame alignment sends ones then zeros on each wire msb first, zeros then ones lsb first, half and half but 4 ones, 3 zeros at 7 bits
// - zeros, ones and toggle patterns go to both channels together
// - toggle alternates alternating-bit word and its complement per sample
// - custom word from two registers, split by serialization and order
// - sample leaves eleven sample clocks after being taken
// - serializer latency 0, 1 or 2 by interface mode
// - bit clock edges sit mid-bit on the data in ddr; in sdr only the rising edge does, the fall comes with the data change
// - each word starts at frame clock rise, msb first by default
// - 14x serialization pads two zero bits on the msb side
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ns
module afs_top
  import afs_pkg::*;
#(
  parameter int PIPE_N = 14
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic sample_clk_in,
  input wire logic [11:0] code_a_in,
  input wire logic [11:0] code_b_in,
  input wire logic [1:0] ovr_pos_in,
  input wire logic [1:0] ovr_neg_in,
  output logic [3:0] data_out,
  output logic bit_clock_out,
  output logic frame_clock_out,
  output logic [1:0] driver_current_select_out,
  output logic current_double_enable_out,
  output logic [4:0] drive_units_out,
  output logic [4:0] term_clk_out,
  output logic [4:0] term_data_out
);
  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic [1:0][11:0] code_m;
    logic [1:0][11:0] code_s;
    logic [1:0] ovp_m;
    logic [1:0] ovp_s;
    logic [1:0] ovn_m;
    logic [1:0] ovn_s;
    logic [31:0] ctrl;
    logic [31:0] drive;
    logic [5:0] cust_lo;
    logic [5:0] cust_hi;
    logic ack;
    logic [31:0] rdat;
    logic [PIPE_N-1:0][1:0][11:0] pipe;
    logic tog;
    logic [1:0] ph;
    logic [3:0] bc;
    logic bck;
    logic frm;
    logic [1:0][11:0] last;
    logic [4:0] units;
  } afs_top_st_t;

  afs_top_st_t s, n;
  logic [1:0] rst_q;
  logic rst_n;
  logic [1:0][11:0] fmt_w;
  logic [1:0][11:0] word_a, word_b;
  logic samp_edge, strobe, acc, load, shift;
  logic [3:0] bc_nxt, len, tap;
  logic [1:0] lat;
  afs_pat_t pat;
  afs_ord_t ord;
  afs_ser_if ser_bus ();

  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] wr,
                                           input logic [3:0] sel,
                                           input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = wr[8*i +: 8];
    end
    return r & mask;
  endfunction

  function automatic logic [11:0] pat_word(input afs_pat_t p,
                                           input logic [11:0] d,
                                           input logic t,
                                           input logic [11:0] c);
    case (p)
      PAT_ZERO: pat_word = 12'h000;
      PAT_ONE: pat_word = 12'hfff;
      PAT_TOG: pat_word = t ? TOG_LO : TOG_HI;
      PAT_CUST: pat_word = c;
      default: pat_word = d;
    endcase
  endfunction

  function automatic logic [4:0] cur_units(input logic [1:0] cur);
    case (cur)
      CUR_2P5: cur_units = UNITS_2P5;
      CUR_3P0: cur_units = UNITS_3P0;
      CUR_4P5: cur_units = UNITS_4P5;
      default: cur_units = UNITS_3P5;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      afs_fmt u_fmt (
        .code_in(s.code_s[ch]),
        .ovp_in(s.ovp_s[ch]),
        .ovn_in(s.ovn_s[ch]),
        .offset_bin_in(s.ctrl[CTRL_FMT]),
        .word_out(fmt_w[ch])
      );
      afs_ser u_ser (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .cfg(ser_bus.ser),
        .word_a_in(word_a[ch]),
        .word_b_in(word_b[ch]),
        .wire_out(data_out[2*ch +: 2])
      );
    end
  endgenerate

  assign pat = afs_pat_t'(s.ctrl[CTRL_PAT +: 3]);
  assign ord = afs_ord_t'(s.ctrl[CTRL_ORD +: 2]);
  // deep pipeline tap so the latency follows the mode at load time
  assign lat = ser_lat(s.ctrl[CTRL_TWO], s.ctrl[CTRL_DDR], s.ctrl[CTRL_S14],
                       s.ctrl[CTRL_LONG]);
  assign tap = ADC_TAP + {2'b00, lat};

  // bits per wire in one frame
  always_comb begin
    len = s.ctrl[CTRL_S14] ? BITS_14X : BITS_12X;
    if (s.ctrl[CTRL_TWO] && ord != ORD_WORD) begin
      len = len >> 1;
    end
  end

  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      word_a[ch] = pat_word(pat, s.pipe[tap][ch], s.tog,
                            {s.cust_hi, s.cust_lo});
      word_b[ch] = pat_word(pat, s.pipe[tap - 4'h1][ch], ~s.tog,
                            {s.cust_hi, s.cust_lo});
    end
  end

  assign ser_bus.load = load;
  assign ser_bus.shift = shift;
  assign ser_bus.len = len;
  assign ser_bus.lsb = s.ctrl[CTRL_LSB];
  assign ser_bus.two = s.ctrl[CTRL_TWO];
  assign ser_bus.word = (ord == ORD_WORD);
  assign ser_bus.bitw = (ord == ORD_BIT);
  assign ser_bus.wpat = (pat == PAT_SYNC) ? WP_SYNC :
                        (pat == PAT_DESK) ? WP_DESK : WP_DATA;

  assign samp_edge = s.sclk_s & ~s.sclk_d;
  assign strobe = (s.ph == 2'(BIT_CLKS - 1));
  assign bc_nxt = (s.bc >= len - 4'h1) ? 4'h0 : s.bc + 4'h1;
  assign load = strobe && (bc_nxt == 4'h0);
  assign shift = strobe && (bc_nxt != 4'h0);
  assign acc = wb_cyc_in & wb_stb_in & ~s.ack;

  always_comb begin
    n = s;
    // two-flop synchronisers on everything from the converter side
    n.sclk_m = sample_clk_in;
    n.sclk_s = s.sclk_m;
    n.sclk_d = s.sclk_s;
    n.code_m = {code_b_in, code_a_in};
    n.code_s = s.code_m;
    n.ovp_m = ovr_pos_in;
    n.ovp_s = s.ovp_m;
    n.ovn_m = ovr_neg_in;
    n.ovn_s = s.ovn_m;
    // sample pipeline, one step per sample clock rise
    if (samp_edge) begin
      n.pipe = {s.pipe[PIPE_N-2:0], fmt_w};
      n.tog = ~s.tog;
    end
    // wishbone: ack one cycle after the request, dropped the next cycle
    n.ack = acc;
    if (acc && wb_we_in) begin
      case (wb_adr_in)
        REG_CTRL: n.ctrl = wb_merge(s.ctrl, wb_dat_in, wb_sel_in, CTRL_MASK);
        REG_DRIVE: n.drive = wb_merge(s.drive, wb_dat_in, wb_sel_in,
                                      DRIVE_MASK);
        REG_CUST_LO: begin
          if (wb_sel_in[0]) n.cust_lo = wb_dat_in[5:0];
        end
        REG_CUST_HI: begin
          if (wb_sel_in[0]) n.cust_hi = wb_dat_in[5:0];
        end
        default: n.ack = acc;
      endcase
    end
    if (acc && !wb_we_in) begin
      case (wb_adr_in)
        REG_CTRL: n.rdat = s.ctrl;
        REG_DRIVE: n.rdat = s.drive;
        REG_CUST_LO: n.rdat = {26'h0, s.cust_lo};
        REG_CUST_HI: n.rdat = {26'h0, s.cust_hi};
        REG_STAT: n.rdat = {4'h0, s.last[1], 4'h0, s.last[0]};
        default: n.rdat = 32'h0000_0000;
      endcase
    end
    // effective driver current in half-ma steps
    n.units = cur_units(s.drive[DRV_CUR +: 2]) << s.drive[DRV_DBL];
    // bit timing: data moves at phase 0, clock edge two phases later
    n.ph = strobe ? 2'h0 : s.ph + 2'h1;
    if (strobe) begin
      n.bc = bc_nxt;
      // rises only with a load, so no frame edge without a word after reset
      n.frm = load || (s.frm && (bc_nxt < ((len + 4'h1) >> 1)));
    end
    if (s.ctrl[CTRL_DDR]) begin
      if (n.ph == 2'(BIT_CLKS / 2)) n.bck = ~s.bck;
    end else begin
      n.bck = (n.ph >= 2'(BIT_CLKS / 2));
    end
    if (load) begin
      n.last = word_a;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.drive <= DRIVE_RST;
      s.cust_lo <= CUST_RST;
      s.cust_hi <= CUST_RST;
      s.units <= UNITS_3P5;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_out = s.rdat;
  assign wb_ack_out = s.ack;
  assign bit_clock_out = s.bck;
  assign frame_clock_out = s.frm;
  assign driver_current_select_out = s.drive[DRV_CUR +: 2];
  assign current_double_enable_out = s.drive[DRV_DBL];
  assign drive_units_out = s.units;
  assign term_clk_out = s.drive[DRV_TCLK +: 5];
  assign term_data_out = s.drive[DRV_TDAT +: 5];
endmodule // afs_top

// file: logic/afs_pkg.sv
// constants, field layout and types of the serial output formatter
// assumes a 32-bit classic wishbone host and a 12-bit converter core
package afs_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DRIVE = 8'h04;
  localparam logic [7:0] REG_CUST_LO = 8'h08;
  localparam logic [7:0] REG_CUST_HI = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  // control fields
  localparam int CTRL_FMT = 0;
  localparam int CTRL_LSB = 1;
  localparam int CTRL_TWO = 2;
  localparam int CTRL_S14 = 3;
  localparam int CTRL_DDR = 4;
  localparam int CTRL_ORD = 5;
  localparam int CTRL_LONG = 7;
  localparam int CTRL_PAT = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_07ff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // drive fields
  localparam int DRV_CUR = 0;
  localparam int DRV_DBL = 2;
  localparam int DRV_TCLK = 3;
  localparam int DRV_TDAT = 8;
  localparam logic [31:0] DRIVE_MASK = 32'h0000_1fff;
  localparam logic [31:0] DRIVE_RST = 32'h0000_0000;
  localparam logic [5:0] CUST_RST = 6'h00;
  // driver current codes and their value in 0.5 ma units
  localparam logic [1:0] CUR_3P5 = 2'h0;
  localparam logic [1:0] CUR_2P5 = 2'h1;
  localparam logic [1:0] CUR_3P0 = 2'h2;
  localparam logic [1:0] CUR_4P5 = 2'h3;
  localparam logic [4:0] UNITS_3P5 = 5'h07;
  localparam logic [4:0] UNITS_2P5 = 5'h05;
  localparam logic [4:0] UNITS_3P0 = 5'h06;
  localparam logic [4:0] UNITS_4P5 = 5'h09;
  // output codes
  localparam logic [11:0] OB_POS_FS = 12'hfff;
  localparam logic [11:0] TC_POS_FS = 12'h7ff;
  localparam logic [11:0] OB_NEG_FS = 12'h000;
  localparam logic [11:0] TC_NEG_FS = 12'h800;
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam logic [11:0] TOG_HI = 12'haaa;
  localparam logic [11:0] TOG_LO = 12'h555;
  // timing
  localparam logic [3:0] ADC_TAP = 4'hb;
  localparam logic [3:0] BITS_12X = 4'hc;
  localparam logic [3:0] BITS_14X = 4'he;
  localparam int BIT_CLKS = 4;
  typedef enum logic [1:0] {ORD_BYTE, ORD_BIT, ORD_WORD} afs_ord_t;
  typedef enum logic [2:0] {
    PAT_NONE, PAT_ZERO, PAT_ONE, PAT_TOG, PAT_CUST, PAT_SYNC, PAT_DESK
  } afs_pat_t;
  typedef enum logic [1:0] {WP_DATA, WP_SYNC, WP_DESK} afs_wpat_t;
  function automatic logic [1:0] ser_lat(input logic two, input logic ddr,
                                          input logic s14, input logic long_dly);
    if (!two || !ddr) return 2'h0;
    if (!s14) return 2'h1;
    return long_dly ? 2'h2 : 2'h1;
  endfunction
endpackage

// file: logic/afs_ser_if.sv
// frame control shared by the per-channel serializers
// driven by the top on its own clock
`timescale 1ns/1ns
interface afs_ser_if;
  logic load;
  logic shift;
  logic [3:0] len;
  logic lsb;
  logic two;
  logic word;
  logic bitw;
  afs_pkg::afs_wpat_t wpat;
  modport ctl (output load, shift, len, lsb, two, word, bitw, wpat);
  modport ser (input load, shift, len, lsb, two, word, bitw, wpat);
endinterface

// file: logic/afs_fmt.sv
// output coding and overdrive clamp of one channel
// assumes the core code is offset binary
`timescale 1ns/1ns
module afs_fmt
  import afs_pkg::*;
(
  input wire logic [11:0] code_in,
  input wire logic ovp_in,
  input wire logic ovn_in,
  input wire logic offset_bin_in,
  output logic [11:0] word_out
);
  always_comb begin
    if (ovp_in) begin
      word_out = offset_bin_in ? OB_POS_FS : TC_POS_FS;
    end else if (ovn_in) begin
      word_out = offset_bin_in ? OB_NEG_FS : TC_NEG_FS;
    end else begin
      word_out = offset_bin_in ? code_in : (code_in ^ SIGN_FLIP);
    end
  end
endmodule // afs_fmt

// file: logic/afs_ser.sv
// two-wire serializer of one channel
// assumes load and shift come from the same clock, one bit per shift
`timescale 1ns/1ns
module afs_ser
  import afs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  afs_ser_if.ser cfg,
  input wire logic [11:0] word_a_in,
  input wire logic [11:0] word_b_in,
  output logic [1:0] wire_out
);
  typedef struct packed {
    logic [1:0][13:0] vec;
    logic [3:0] idx;
    logic [1:0] wo;
  } afs_ser_st_t;
  afs_ser_st_t s, n;
  logic [1:0][13:0] vecs;
  logic [13:0] wa, wb;

  function automatic logic pick(input logic [13:0] v, input logic [3:0] len,
                                input logic [3:0] k, input logic lsb);
    logic [3:0] pos;
    pos = lsb ? k : 4'(len - 4'h1 - k);
    return v[pos];
  endfunction

  assign wa = {2'b00, word_a_in};
  assign wb = {2'b00, word_b_in};

  always_comb begin
    vecs = '0;
    for (int i = 0; i < 14; i++) begin
      if (4'(i) < cfg.len) begin
        if (cfg.wpat == WP_SYNC) begin
          vecs[0][i] = (4'(i) >= (cfg.len >> 1));
        end else if (cfg.wpat == WP_DESK) begin
          vecs[0][i] = (i[0] == cfg.len[0]) ? 1'b0 : 1'b1;
        end
      end
    end
    if (cfg.wpat != WP_DATA) begin
      vecs[1] = cfg.two ? vecs[0] : 14'h0000;
    end else if (!cfg.two || cfg.word) begin
      vecs[0] = wa;
      vecs[1] = cfg.two ? wb : 14'h0000;
    end else if (cfg.bitw) begin
      for (int j = 0; j < 7; j++) begin
        vecs[0][j] = wa[2 * j];
        vecs[1][j] = wa[2 * j + 1];
      end
    end else begin
      vecs[0] = wa & ~(14'h3fff << cfg.len);
      vecs[1] = wa >> cfg.len;
    end
  end

  always_comb begin
    n = s;
    if (cfg.load) begin
      n.vec = vecs;
      n.idx = 4'h1;
      for (int w = 0; w < 2; w++) n.wo[w] = pick(vecs[w], cfg.len, 4'h0, cfg.lsb);
    end else if (cfg.shift) begin
      n.idx = s.idx + 4'h1;
      for (int w = 0; w < 2; w++) n.wo[w] = pick(s.vec[w], cfg.len, s.idx, cfg.lsb);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign wire_out = s.wo;
endmodule // afs_ser

// file: tb/afs_properties.sv
// port checks of the serial output formatter
// assumes a master that holds each request until ack
`timescale 1ns/1ns
module afs_properties
  import afs_pkg::*;
#(
  parameter int PIPE_N = 14
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_ack_out,
  input wire logic [3:0] data_out,
  input wire logic bit_clock_out,
  input wire logic frame_clock_out,
  input wire logic [1:0] driver_current_select_out,
  input wire logic current_double_enable_out,
  input wire logic [4:0] drive_units_out,
  input wire logic [4:0] term_clk_out,
  input wire logic [4:0] term_data_out
);
  logic [4:0] units_exp;
  logic drive_wr;
  always_comb begin
    case (driver_current_select_out)
      CUR_2P5: units_exp = UNITS_2P5;
      CUR_3P0: units_exp = UNITS_3P0;
      CUR_4P5: units_exp = UNITS_4P5;
      default: units_exp = UNITS_3P5;
    endcase
    if (current_double_enable_out) begin
      units_exp = units_exp << 1;
    end
  end
  // settings may only move on the ack of a drive write
  assign drive_wr = wb_ack_out && wb_we_in && (wb_adr_in == REG_DRIVE);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_hold3(sig);
    $stable(sig) [*3];
  endsequence
  AST_ACK_NEXT:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack");
  AST_ACK_PULSE:
    assert property (wb_ack_out |=> !wb_ack_out)
    else $error("long ack");
  AST_UNITS:
    assert property ($stable({driver_current_select_out, current_double_enable_out})
      |-> drive_units_out == units_exp)
    else $error("bad units");
  AST_DRV_WRITE:
    assert property ($changed({driver_current_select_out, current_double_enable_out})
      |-> drive_wr)
    else $error("current moved");
  AST_TERM_CLK:
    assert property ($changed(term_clk_out) |-> drive_wr)
    else $error("clk term moved");
  AST_TERM_DATA:
    assert property ($changed(term_data_out) |-> drive_wr)
    else $error("data term moved");
  AST_BIT_HOLD:
    assert property ($changed(data_out) |=> s_hold3(data_out))
    else $error("short bit");
  AST_MID_BIT:
    assert property ($changed(data_out) |-> ##2 $changed(bit_clock_out))
    else $error("bit clock off centre");
  AST_FRAME_HOLD:
    assert property ($changed(frame_clock_out) |=> s_hold3(frame_clock_out))
    else $error("frame edge off bit");
endmodule // afs_properties

bind afs_top afs_properties #(.PIPE_N(PIPE_N)) u_props (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_ack_out(wb_ack_out),
  .data_out(data_out), .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out),
  .driver_current_select_out(driver_current_select_out),
  .current_double_enable_out(current_double_enable_out),
  .drive_units_out(drive_units_out), .term_clk_out(term_clk_out),
  .term_data_out(term_data_out));

// file: tb/afs_rx_model.sv
// deserializing receiver on the far side of the link
// assumes sdr; takes wire 0 of each channel and wire 1 of channel a
`timescale 1ns/1ns
module afs_rx_model (
  input wire logic clk_in,
  input wire logic [3:0] data_in,
  input wire logic bclk_in,
  input wire logic fclk_in,
  output logic [13:0] word_a_out,
  output logic [13:0] word_b_out,
  output logic [13:0] word_a1_out,
  output int frames_out
);
  logic [13:0] sh_a = 14'h0;
  logic [13:0] sh_a1 = 14'h0;
  int fcnt = 0;
  logic [13:0] sh_b = 14'h0;
  logic bq = 1'b0;
  logic fq = 1'b0;
  assign frames_out = fcnt;
  always @(posedge clk_in) begin
    bq <= bclk_in;
    fq <= fclk_in;
    if (bclk_in && !bq) begin
      sh_a <= {sh_a[12:0], data_in[0]};
      sh_a1 <= {sh_a1[12:0], data_in[1]};
      sh_b <= {sh_b[12:0], data_in[2]};
    end
    // word boundary from frame clock, not from counting bits
    if (fclk_in && !fq) begin
      word_a_out <= sh_a;
      word_b_out <= sh_b;
      word_a1_out <= sh_a1;
      fcnt <= fcnt + 1;
    end
  end
endmodule // afs_rx_model

// file: tb/testbench.sv
// self-checking bench of the serial output formatter
// assumes one-wire sdr msb first unless a case sets otherwise
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import afs_pkg::*;
  logic clk_in = 0, arst_n_in = 0, cyc = 0, stb = 0, we = 0, sclk = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd, w;
  logic [11:0] ca = 12'h0, cb = 12'h0, rv;
  logic [1:0] ovp = 2'h0, ovn = 2'h0, cur;
  logic [2:0] scnt = 3'h0;
  logic [3:0] dat;
  logic [4:0] units, tclk, tdat;
  logic [13:0] wa, wb, wa1;
  logic ack, bclk, fclk, dbl;
  int frames, error_cnt = 0, checks = 0, seed = 30228, i, e;
  afs_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .sample_clk_in(sclk), .code_a_in(ca), .code_b_in(cb),
    .ovr_pos_in(ovp), .ovr_neg_in(ovn), .data_out(dat), .bit_clock_out(bclk),
    .frame_clock_out(fclk), .driver_current_select_out(cur), .current_double_enable_out(dbl),
    .drive_units_out(units), .term_clk_out(tclk), .term_data_out(tdat));
  afs_rx_model rx (.clk_in(clk_in), .data_in(dat), .bclk_in(bclk), .fclk_in(fclk),
    .word_a_out(wa), .word_b_out(wb), .word_a1_out(wa1), .frames_out(frames));
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    scnt <= scnt + 3'h1;
    sclk <= scnt[2];
  end
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    do begin @(posedge clk_in); n++; end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
    if (n >= 50) begin error_cnt++; complete_run(); end
  endtask
  task automatic wait_fr(input int k);
    int n, f0;
    n = 0;
    f0 = frames;
    while (frames < f0 + k && n < 2000) begin @(posedge clk_in); n++; end
    if (n >= 2000) begin error_cnt++; complete_run(); end
  endtask
  function automatic int expw(int p, int c, int f, int ov, int cu);
    case (p)
      0: return ov == 1 ? (f ? 'hfff : 'h7ff) : ov == 2 ? (f ? 0 : 'h800) : (f ? c : c ^ 'h800);
      1: return 0;
      2: return 'hfff;
      4: return cu;
      5: return 'hfc0;
      default: return 'haaa;
    endcase
  endfunction
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK(units, 5'h07)
    bus(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    for (i = 0; i < 8; i++) begin
      w = 32'($random(seed)) & DRIVE_MASK;
      w[2:0] = i[2:0];
      bus(1'b1, REG_DRIVE, w);
      @(posedge clk_in);
      e = (i % 4 == 0) ? 7 : (i % 4 == 1) ? 5 : (i % 4 == 2) ? 6 : 9;
      `CHK(units, 5'(e << (i / 4)))
      `CHK({tdat, tclk, dbl, cur}, w[12:0])
      bus(1'b0, REG_DRIVE, 32'h0);
      `CHK(rd, w)
    end
    // clamp one channel high and the other low in each coding
    for (i = 0; i < 4; i++) begin
      ca <= 12'($random(seed));
      cb <= 12'($random(seed));
      ovp <= {1'b0, i[1]};
      ovn <= {i[1], 1'b0};
      bus(1'b1, REG_CTRL, 32'(i % 2));
      wait_fr(5);
      `CHK(wa[11:0], 12'(expw(0, ca, i % 2, i[1] ? 1 : 0, 0)))
      `CHK(wb[11:0], 12'(expw(0, cb, i % 2, i[1] ? 2 : 0, 0)))
    end
    for (i = 1; i < 7; i++) begin
      w = 32'($random(seed));
      bus(1'b1, REG_CUST_LO, {26'h0, w[5:0]});
      bus(1'b1, REG_CUST_HI, {26'h0, w[11:6]});
      bus(1'b1, REG_CTRL, 32'(i << CTRL_PAT));
      wait_fr(5);
      e = expw(i, 0, 0, 0, w[11:0]);
      // toggle may show either phase in a frame; deskew starts on a one when msb first but passes either phase here
      `CHK((e == 'haaa && wa[11:0] === 12'h555) ? 12'haaa : wa[11:0], 12'(e))
      `CHK(wb[11:0], wa[11:0])
    end
    rv = {<<{w[11:0]}};
    bus(1'b1, REG_CTRL, 32'((PAT_CUST << CTRL_PAT) | (1 << CTRL_LSB)));
    wait_fr(5);
    `CHK(wa[11:0], rv)
    bus(1'b1, REG_CTRL, 32'((PAT_CUST << CTRL_PAT) | (1 << CTRL_S14)));
    wait_fr(5);
    `CHK(wa, {2'b00, w[11:0]})
    // two wires, byte-wise: low six bits on wire 0, high six on wire 1
    e = (PAT_CUST << CTRL_PAT) | (1 << CTRL_TWO);
    bus(1'b1, REG_CTRL, 32'(e));
    wait_fr(5);
    `CHK({wa1[5:0], wa[5:0]}, w[11:0])
    // two wires, bit-wise: even bits on wire 0, odd bits on wire 1
    bus(1'b1, REG_CTRL, 32'(e | (ORD_BIT << CTRL_ORD)));
    wait_fr(5);
    for (i = 0; i < 6; i++) begin
      rv[2 * i] = wa[i];
      rv[2 * i + 1] = wa1[i];
    end
    `CHK(rv, w[11:0])
    bus(1'b0, REG_STAT, 32'h0);
    `CHK(rd, {4'h0, w[11:0], 4'h0, w[11:0]})
    complete_run();
  end
endmodule // testbench
